// ---- mic_pkg.sv ----
// constants for the miscellaneous irq, clock and spi control block
// Summary of operation
// [RULE1] register 1 bits 7:6 set group one sensitivity, four-way encoding
// [RULE2] register 1 bits 4:3 set group zero sensitivity, same encoding
// [RULE3] sensitivity fields accept writes only while both cpu mask bits are one
// [RULE4] group one from port b, group zero from port a, port c optional
// [RULE5] register 1 bit 5 drives cpu clock onto clock out pin
// [RULE6] slow mode divides oscillator clock by 2, 4, 8 or 16
// [RULE7] register 1 bit 0 selects normal or slow clock mode
// [RULE8] register 2 bits 7:4 reserved, always read zero
// [RULE9] register 2 bit 3 suppresses spi master data output
// [RULE10] register 2 bit 2 suppresses spi slave data output
// [RULE11] register 2 bit 1 selects slave select from pin or bit 0
// [RULE12] internal select source releases the slave select pin for gpio
// [RULE13] reset clears every field of both registers
// [RULE14] software uses only one copy of the spi pin control bits
// [RULE15] one setting per group for all lines, groups independent
// [RULE16] blocked sensitivity write keeps field, other bits still update
// [RULE17] edges found by comparing samples; low level requests every cycle
package mic_pkg;
  localparam logic [7:0] MIC_CTRL_OFFS     = 8'h20;
  localparam logic [7:0] MIC_SPI_OFFS      = 8'h40;
  localparam logic [7:0] MIC_IRQ_STAT_OFFS = 8'h60;
  localparam logic [7:0] MIC_IRQ_MASK_OFFS = 8'h61;
  localparam logic [7:0] MIC_CTRL_RST      = 8'h00;
  localparam logic [3:0] MIC_SPI_RST       = 4'h0;
  localparam int G1_SENSE_POS = 6;
  localparam int CLK_OUT_POS  = 5;
  localparam int G0_SENSE_POS = 3;
  localparam int DIV_POS      = 1;
  localparam int SLOW_POS     = 0;
  localparam int MOSI_DIS_POS = 3;
  localparam int MISO_DIS_POS = 2;
  localparam int SS_OVR_POS   = 1;
  localparam int SS_LVL_POS   = 0;
  typedef enum logic [1:0] {
    MIC_FALL_LOW = 2'b00,
    MIC_RISE     = 2'b01,
    MIC_FALL     = 2'b10,
    MIC_BOTH     = 2'b11
  } mic_sense_t;
  localparam logic [4:0] MIC_DIV2_HALF  = 5'h00;
  localparam logic [4:0] MIC_DIV4_HALF  = 5'h01;
  localparam logic [4:0] MIC_DIV8_HALF  = 5'h03;
  localparam logic [4:0] MIC_DIV16_HALF = 5'h07;
endpackage : mic_pkg

// ---- mic_misc_ctrl.sv ----
// miscellaneous control registers: irq sensitivity, cpu clock, spi overrides
`timescale 1ns/1ps
module mic_misc_ctrl
  import mic_pkg::*;
#(
  parameter int PA_W = 8,
  parameter int PB_W = 8,
  parameter int PC_W = 6
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [7:0]      addr_in,
  input  wire logic [7:0]      wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output logic      [7:0]      rdata_out,
  input  wire logic [1:0]      cpu_irq_mask_in,
  input  wire logic            irq_source_route_option_in,
  input  wire logic            port_c_to_group_one_in,
  input  wire logic [PA_W-1:0] port_a_in,
  input  wire logic [PB_W-1:0] port_b_in,
  input  wire logic [PC_W-1:0] port_c_in,
  output logic                 ext_irq_group_one_out,
  output logic                 ext_irq_group_zero_out,
  output logic                 cpu_clk_en_out,
  output logic                 clock_out_pin_out,
  output logic                 clock_out_pin_oe_n_out,
  input  wire logic            spi_mosi_in,
  input  wire logic            spi_mosi_oe_n_in,
  input  wire logic            spi_miso_in,
  input  wire logic            spi_miso_oe_n_in,
  output logic                 mosi_pin_out,
  output logic                 mosi_pin_oe_n_out,
  output logic                 miso_pin_out,
  output logic                 miso_pin_oe_n_out,
  input  wire logic            slave_select_pin_in,
  output logic                 spi_select_n_out,
  output logic                 slave_select_pin_free_out,
  output logic                 irq_out
);
  localparam int NL = PA_W + PB_W + PC_W;

  logic [7:0]      ctrl_reg;
  logic [3:0]      spi_reg;
  logic [1:0]      stat_reg;
  logic [1:0]      mask_reg;
  logic [NL-1:0]   pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic            ss_s1_reg, ss_s2_reg;
  logic [4:0]      div_cnt_reg;
  logic            div_phase_reg;
  logic [4:0]      half_limit;
  logic            cpu_tick;
  logic            masked;
  logic            wr_ctrl;
  logic [NL-1:0]   pin_now, rise, fall, req;
  logic [NL-1:0]   in_g1, in_g0;
  logic            g1_hit, g0_hit;
  mic_sense_t      g1_sense, g0_sense;
  logic [7:0]      rdata_next;

  assign masked   = &cpu_irq_mask_in;
  assign wr_ctrl  = wr_in && (addr_in == MIC_CTRL_OFFS);
  assign g1_sense = mic_sense_t'(ctrl_reg[G1_SENSE_POS +: 2]);
  assign g0_sense = mic_sense_t'(ctrl_reg[G0_SENSE_POS +: 2]);

  // control register write, sense fields guarded
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // [RULE13] reset clears fields
      ctrl_reg <= MIC_CTRL_RST;
    end else if (wr_ctrl) begin
      // [RULE16] other bits always update
      ctrl_reg[CLK_OUT_POS] <= wdata_in[CLK_OUT_POS];
      ctrl_reg[DIV_POS +: 2] <= wdata_in[DIV_POS +: 2];
      ctrl_reg[SLOW_POS] <= wdata_in[SLOW_POS];
      // [RULE3] write only when masked
      if (masked) begin
        // [RULE1] group one sense field
        ctrl_reg[G1_SENSE_POS +: 2] <= wdata_in[G1_SENSE_POS +: 2];
        // [RULE2] group zero sense field
        ctrl_reg[G0_SENSE_POS +: 2] <= wdata_in[G0_SENSE_POS +: 2];
      end
    end
  end

  // spi override register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      spi_reg <= MIC_SPI_RST;
    end else if (wr_in && (addr_in == MIC_SPI_OFFS)) begin
      spi_reg <= wdata_in[3:0];
    end
  end

  // slow clock divider half periods
  always_comb begin
    unique case (ctrl_reg[DIV_POS +: 2])
      2'b00: half_limit = MIC_DIV2_HALF;
      2'b10: half_limit = MIC_DIV4_HALF;
      2'b01: half_limit = MIC_DIV8_HALF;
      2'b11: half_limit = MIC_DIV16_HALF;
    endcase
  end

  // divider counter and phase of the cpu clock
  always_ff @(posedge clk_in) begin
    if (rst_in || !ctrl_reg[SLOW_POS]) begin
      div_cnt_reg   <= 5'h00;
      div_phase_reg <= 1'b0;
    end else if (div_cnt_reg >= half_limit) begin
      div_cnt_reg   <= 5'h00;
      div_phase_reg <= ~div_phase_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  // [RULE7] normal mode ticks every cycle
  // [RULE6] slow mode ticks once per divided period
  assign cpu_tick = !ctrl_reg[SLOW_POS] ||
                    (div_phase_reg && (div_cnt_reg >= half_limit));

  // cpu clock enable and clock out pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cpu_clk_en_out         <= 1'b0;
      clock_out_pin_out      <= 1'b0;
      clock_out_pin_oe_n_out <= 1'b1;
    end else begin
      cpu_clk_en_out <= cpu_tick;
      // [RULE5] cpu clock on pin when enabled
      clock_out_pin_oe_n_out <= !ctrl_reg[CLK_OUT_POS];
      clock_out_pin_out      <= ctrl_reg[SLOW_POS] ? div_phase_reg : ~clock_out_pin_out;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      ss_s1_reg  <= 1'b1;
      ss_s2_reg  <= 1'b1;
    end else begin
      pin_s1_reg <= {port_c_in, port_b_in, port_a_in};
      pin_s2_reg <= pin_s1_reg;
      ss_s1_reg  <= slave_select_pin_in;
      ss_s2_reg  <= ss_s1_reg;
    end
  end

  // previous sample taken on the cpu clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_prev_reg <= '1;
    end else if (cpu_tick) begin
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // [RULE17] compare sample with previous one
  assign pin_now = pin_s2_reg;
  assign rise    = pin_now & ~pin_prev_reg;
  assign fall    = ~pin_now & pin_prev_reg;

  // [RULE4] group membership of the lines
  always_comb begin
    in_g1 = '0;
    in_g0 = '0;
    in_g0[PA_W-1:0] = '1;
    in_g1[PA_W +: PB_W] = '1;
    if (irq_source_route_option_in) begin
      if (port_c_to_group_one_in) begin
        in_g1[PA_W+PB_W +: PC_W] = '1;
      end else begin
        in_g0[PA_W+PB_W +: PC_W] = '1;
      end
    end
  end

  // [RULE15] one setting per group
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      unique case (in_g1[i] ? g1_sense : g0_sense)
        MIC_FALL_LOW: req[i] = fall[i] | ~pin_now[i];
        MIC_RISE:     req[i] = rise[i];
        MIC_FALL:     req[i] = fall[i];
        MIC_BOTH:     req[i] = rise[i] | fall[i];
      endcase
    end
  end

  assign g1_hit = cpu_tick && |(req & in_g1);
  assign g0_hit = cpu_tick && |(req & in_g0);

  // group request pulses toward the cpu
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_irq_group_one_out  <= 1'b0;
      ext_irq_group_zero_out <= 1'b0;
    end else begin
      ext_irq_group_one_out  <= g1_hit;
      ext_irq_group_zero_out <= g0_hit;
    end
  end

  // sticky status, set beats write-one clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_reg <= 2'b00;
    end else begin
      stat_reg <= (stat_reg & ~((wr_in && addr_in == MIC_IRQ_STAT_OFFS) ? wdata_in[1:0] : 2'b00))
                  | {g1_hit, g0_hit};
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_reg <= 2'b00;
    end else if (wr_in && addr_in == MIC_IRQ_MASK_OFFS) begin
      mask_reg <= wdata_in[1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_reg & mask_reg);
    end
  end

  // spi pin gating
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mosi_pin_out              <= 1'b0;
      mosi_pin_oe_n_out         <= 1'b1;
      miso_pin_out              <= 1'b0;
      miso_pin_oe_n_out         <= 1'b1;
      spi_select_n_out          <= 1'b1;
      slave_select_pin_free_out <= 1'b0;
    end else begin
      mosi_pin_out <= spi_mosi_in;
      miso_pin_out <= spi_miso_in;
      // [RULE9] master output suppressed
      mosi_pin_oe_n_out <= spi_mosi_oe_n_in | spi_reg[MOSI_DIS_POS];
      // [RULE10] slave output suppressed
      miso_pin_oe_n_out <= spi_miso_oe_n_in | spi_reg[MISO_DIS_POS];
      // [RULE11] select level source
      spi_select_n_out <= spi_reg[SS_OVR_POS] ? spi_reg[SS_LVL_POS] : ss_s2_reg;
      // [RULE12] pin released for gpio
      slave_select_pin_free_out <= spi_reg[SS_OVR_POS];
    end
  end

  // read mux
  always_comb begin
    unique case (addr_in)
      MIC_CTRL_OFFS:     rdata_next = ctrl_reg;
      // [RULE8] upper bits read zero
      MIC_SPI_OFFS:      rdata_next = {4'h0, spi_reg};
      MIC_IRQ_STAT_OFFS: rdata_next = {6'h00, stat_reg};
      MIC_IRQ_MASK_OFFS: rdata_next = {6'h00, mask_reg};
      default:           rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // [RULE3] guarded field holds when unmasked
  sense_guard_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
    (wr_ctrl && !masked) |=> ctrl_reg[7:6] == $past(ctrl_reg[7:6]) && ctrl_reg[4:3] == $past(ctrl_reg[4:3]))
    else $error("sense field changed while unmasked");
  // [RULE16] other bits still written
  other_bits_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE16]
    wr_ctrl |=> ctrl_reg[2:0] == $past(wdata_in[2:0]) && ctrl_reg[5] == $past(wdata_in[5]))
    else $error("unguarded bits not written");
  // [RULE1] group one field written when masked
  g1_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
    (wr_ctrl && masked) |=> ctrl_reg[7:6] == $past(wdata_in[7:6]))
    else $error("group one field not written");
  // [RULE8] reserved bits zero
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE8]
    (rd_in && addr_in == MIC_SPI_OFFS) |=> rdata_out[7:4] == 4'h0)
    else $error("reserved bits nonzero");
  // [RULE9] mosi disabled
  mosi_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE9]
    spi_reg[MOSI_DIS_POS] |=> mosi_pin_oe_n_out)
    else $error("mosi driven while disabled");
  // [RULE10] miso disabled
  miso_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE10]
    spi_reg[MISO_DIS_POS] |=> miso_pin_oe_n_out)
    else $error("miso driven while disabled");
  // [RULE11] internal select level used
  ss_internal_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
    spi_reg[SS_OVR_POS] |=> spi_select_n_out == $past(spi_reg[SS_LVL_POS]))
    else $error("internal select level not used");
  // [RULE7] normal mode ticks each cycle
  normal_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
    !ctrl_reg[SLOW_POS] |-> cpu_tick)
    else $error("normal mode missing tick");
  // [RULE6] divide by two spacing
  div2_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE6]
    (cpu_tick && ctrl_reg[2:0] == 3'b001) ##1 (ctrl_reg[2:0] == 3'b001) |-> !cpu_tick ##1 (ctrl_reg[2:0] != 3'b001 || cpu_tick))
    else $error("divide by two spacing wrong");
  // [RULE17] low level keeps requesting
  low_level_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
    (cpu_tick && g0_sense == MIC_FALL_LOW && !pin_now[0]) |=> ext_irq_group_zero_out)
    else $error("low level did not request");
  // [RULE5] clock pin enable follows bit
  clk_out_en_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
    ctrl_reg[CLK_OUT_POS] |=> !clock_out_pin_oe_n_out)
    else $error("clock out not enabled");

  masked_write_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_ctrl && masked);
  slow16_c:       cover property (@(posedge clk_in) disable iff (rst_in) cpu_tick && ctrl_reg[2:0] == 3'b111);
  g1_irq_c:       cover property (@(posedge clk_in) disable iff (rst_in) g1_hit);
  irq_c:          cover property (@(posedge clk_in) disable iff (rst_in) irq_out);
endmodule : mic_misc_ctrl

// ---- mic_far_side_model.sv ----
// far side model: port pins and spi core facing the control block
`timescale 1ns/1ps
module mic_far_side_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pa_level_in,
  input  wire logic       pb_level_in,
  input  wire logic       ss_level_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_b_out,
  output logic      [5:0] port_c_out,
  output logic            spi_mosi_out,
  output logic            spi_mosi_oe_n_out,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_n_out,
  output logic            slave_select_pin_out
);
  // port a lines feed group zero, port b group one
  assign port_a_out = {8{pa_level_in}};
  assign port_b_out = {8{pb_level_in}};
  // port c idles high through its pull-ups
  assign port_c_out = 6'h3f;
  assign slave_select_pin_out = ss_level_in;
  // spi core uses its own control copy only
  always_ff @(posedge clk_in) begin
    spi_mosi_oe_n_out <= rst_in; // active spi drives both data lines
    spi_miso_oe_n_out <= rst_in;
    spi_mosi_out      <= 1'b1;
    spi_miso_out      <= 1'b0;
  end
endmodule : mic_far_side_model

// ---- mic_misc_ctrl_tb_top.sv ----
// self-checking testbench for the miscellaneous control block
`timescale 1ns/1ps
module mic_misc_ctrl_tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] mask;
    logic [7:0] exp;
  } mic_row_t;
  logic clk_in = 1'b0, rst_in, wr_in, rd_in, pa, pb, ss;
  logic [7:0] addr_in, wdata_in, rdata_out, d, n;
  logic [1:0] cpu_irq_mask_in;
  logic [7:0] port_a, port_b;
  logic [5:0] port_c;
  logic irq1, irq0, tick, ck_pin, ck_oe_n, smosi, smosi_oe, smiso, smiso_oe;
  logic mosi, mosi_oe_n, miso, miso_oe_n, ss_pin, sel_n, ss_free, irq_out;
  int err_total = 0, comparisons = 0, cyc = 0;
  mic_row_t rows [7] = '{
    '{8'h20, 8'hff, 2'b11, 8'hff}, '{8'h20, 8'h00, 2'b00, 8'hd8},
    '{8'h20, 8'h21, 2'b01, 8'hf9}, '{8'h20, 8'h00, 2'b11, 8'h00},
    '{8'h40, 8'hff, 2'b00, 8'h0f}, '{8'h40, 8'h05, 2'b10, 8'h05},
    '{8'h33, 8'haa, 2'b11, 8'h00}};
  logic [7:0] div_wr  [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
  logic [7:0] div_exp [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
  logic [7:0] spi_wr  [3] = '{8'h08, 8'h04, 8'h00};
  logic [1:0] spi_exp [3] = '{2'b10, 2'b01, 2'b00};

  mic_misc_ctrl dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cpu_irq_mask_in(cpu_irq_mask_in),
    .irq_source_route_option_in(1'b0), .port_c_to_group_one_in(1'b0), .port_a_in(port_a),
    .port_b_in(port_b), .port_c_in(port_c), .ext_irq_group_one_out(irq1), .ext_irq_group_zero_out(irq0),
    .cpu_clk_en_out(tick), .clock_out_pin_out(ck_pin), .clock_out_pin_oe_n_out(ck_oe_n),
    .spi_mosi_in(smosi), .spi_mosi_oe_n_in(smosi_oe), .spi_miso_in(smiso), .spi_miso_oe_n_in(smiso_oe),
    .mosi_pin_out(mosi), .mosi_pin_oe_n_out(mosi_oe_n), .miso_pin_out(miso), .miso_pin_oe_n_out(miso_oe_n),
    .slave_select_pin_in(ss_pin), .spi_select_n_out(sel_n), .slave_select_pin_free_out(ss_free),
    .irq_out(irq_out));
  mic_far_side_model far_u (.clk_in(clk_in), .rst_in(rst_in), .pa_level_in(pa), .pb_level_in(pb),
    .ss_level_in(ss), .port_a_out(port_a), .port_b_out(port_b), .port_c_out(port_c),
    .spi_mosi_out(smosi), .spi_mosi_oe_n_out(smosi_oe), .spi_miso_out(smiso),
    .spi_miso_oe_n_out(smiso_oe), .slave_select_pin_out(ss_pin));

  // 125 MHz core clock
  always #4 clk_in = ~clk_in;

  task automatic results;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd

  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : settle

  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    {rst_in, pa, pb, ss, cpu_irq_mask_in} = 6'h3f;
    {wr_in, rd_in, addr_in, wdata_in} = 18'h0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h20, d);
    chk("ctrl reset", 8'h00, d);
    rd(8'h40, d);
    chk("spi reset", 8'h00, d);
    for (int i = 0; i < 7; i++) begin
      cpu_irq_mask_in <= rows[i].mask;
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk("row readback", rows[i].exp, d);
    end
    cpu_irq_mask_in <= 2'b11;
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, div_wr[i]);
      settle(4);
      n = 8'h00;
      repeat (64) begin
        @(posedge clk_in);
        #1 n = n + {7'h0, tick};
      end
      chk("tick count", div_exp[i], n);
    end
    wr(8'h20, 8'h20);
    settle(3);
    chk("clk out oe", 8'h00, {7'h0, ck_oe_n});
    d = {7'h0, ck_pin};
    settle(1);
    chk("clk out toggles", {7'h0, ~d[0]}, {7'h0, ck_pin});
    wr(8'h20, 8'h00);
    settle(3);
    chk("clk out released", 8'h01, {7'h0, ck_oe_n});
    for (int i = 0; i < 3; i++) begin
      wr(8'h40, spi_wr[i]);
      settle(3);
      chk("spi oe", {6'h0, spi_exp[i]}, {6'h0, mosi_oe_n, miso_oe_n});
    end
    chk("spi data", 8'h02, {6'h0, mosi, miso});
    ss <= 1'b0;
    settle(5);
    chk("select from pin", 8'h00, {6'h0, ss_free, sel_n});
    wr(8'h40, 8'h03);
    settle(3);
    chk("select internal hi", 8'h03, {6'h0, ss_free, sel_n});
    wr(8'h40, 8'h02);
    settle(3);
    chk("select internal lo", 8'h02, {6'h0, ss_free, sel_n});
    // group zero falling edge, interrupt unmasked
    wr(8'h20, 8'h10);
    wr(8'h61, 8'h01);
    pa <= 1'b0;
    settle(8);
    chk("irq on fall", 8'h01, {7'h0, irq_out});
    rd(8'h60, d);
    chk("status fall", 8'h01, d);
    wr(8'h60, 8'h01);
    settle(4);
    chk("irq cleared", 8'h00, {7'h0, irq_out});
    wr(8'h20, 8'h00);
    wr(8'h60, 8'h01);
    settle(6);
    rd(8'h60, d);
    chk("low level repeats", 8'h01, d);
    chk("group zero request", 8'h01, {7'h0, irq0});
    // group one rising edge, interrupt masked out
    pa <= 1'b1;
    wr(8'h20, 8'h40);
    wr(8'h61, 8'h00);
    wr(8'h60, 8'h03);
    pb <= 1'b0;
    settle(8);
    rd(8'h60, d);
    chk("no fall on rise", 8'h00, d);
    chk("group one quiet", 8'h00, {7'h0, irq1});
    pb <= 1'b1;
    settle(8);
    rd(8'h60, d);
    chk("status rise", 8'h02, d);
    chk("irq masked", 8'h00, {7'h0, irq_out});
    wr(8'h61, 8'h02);
    settle(3);
    chk("irq unmasked", 8'h01, {7'h0, irq_out});
    // reset in mid-run clears irq, control and mask registers again
    rst_in <= 1'b1;
    settle(2);
    chk("irq after reset", 8'h00, {7'h0, irq_out});
    rst_in <= 1'b0;
    rd(8'h20, d);
    chk("ctrl reset again", 8'h00, d);
    rd(8'h61, d);
    chk("mask reset again", 8'h00, d);
    results();
  end
endmodule : mic_misc_ctrl_tb_top
